// file: rtl/ebrh_top.sv
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - core reset request resets only the core
// - core drains pipeline before entering reset
// - reset acknowledge is one-cycle pulse
// - acknowledge repeats periodically while request held
// - core restarts fetching at reset address
// - port output bit drives core reset request
// - rising edge on input sets capture bit
// - capture bit stays set until cleared
// - one-bit port, output request, input acknowledge
// - any write to edge register clears it; a rising edge in the same cycle wins
// - output data register at offset zero
module ebrh_top
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  // wishbone slave
  input  wire ebrh_pkg::ebrh_wb_req_s wb_req_i,
  output      ebrh_pkg::ebrh_wb_rsp_s wb_rsp_o,
  // core side
  input  wire logic                  core_pipe_empty_i,
  output      logic                  core_reset_o,
  output      logic                  reset_taken_o,
  output      logic                  boot_fetch_o,
  output      logic [31:0]           boot_addr_o,
  // interrupt
  output      logic                  irq_o
);
  import ebrh_pkg::*;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic access;
  logic wr;
  logic rd;
  logic ack_q;

  assign access = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  // writes land on the acking edge, while the master still holds the request
  assign wr     = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_q;
  assign rd     = access & ~wb_req_i.we;

  // ****************************************************************
  // port registers
  // ****************************************************************
  logic req_q;
  logic edge_q;
  logic mask_q;
  logic taken_q;
  logic taken_prev_q;
  logic rise;

  // held until host writes zero; only the core sees this reset
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      req_q <= EBRH_RST_REQ;
    else if (ce_i && wr && wb_req_i.adr == EBRH_ADR_DATA && wb_req_i.sel[0])
      req_q <= wb_req_i.dat[EBRH_BIT_PORT];
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mask_q <= EBRH_RST_MASK;
    else if (ce_i && wr && wb_req_i.adr == EBRH_ADR_MASK && wb_req_i.sel[0])
      mask_q <= wb_req_i.dat[EBRH_BIT_PORT];
  end

  // port input bit is the acknowledge pulse, sampled once more for edges
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      taken_prev_q <= 1'b0;
    else if (ce_i)
      taken_prev_q <= taken_q;
  end

  assign rise = taken_q & ~taken_prev_q;

  // set beats clear so a pulse landing on the clearing write is kept
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      edge_q <= EBRH_RST_EDGE;
    else if (ce_i)
    begin
      if (rise)
        edge_q <= 1'b1;
      else if (wr && wb_req_i.adr == EBRH_ADR_EDGE)
        edge_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= edge_q & mask_q;
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  logic [31:0] rdata;

  always_comb
  begin
    rdata = EBRH_RST_RDATA;
    unique case (wb_req_i.adr)
      EBRH_ADR_DATA: rdata[EBRH_BIT_PORT] = taken_q;
      EBRH_ADR_MASK: rdata[EBRH_BIT_PORT] = mask_q;
      EBRH_ADR_EDGE: rdata[EBRH_BIT_PORT] = edge_q;
      default:       rdata = EBRH_RST_RDATA;
    endcase
  end

  // unmapped addresses still ack, reading zero and ignoring writes
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ack_q <= 1'b0;
    else if (ce_i)
      ack_q <= access;
  end

  logic [31:0] rdat_q;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdat_q <= EBRH_RST_RDATA;
    else if (ce_i && rd)
      rdat_q <= rdata;
  end

  // one driver for the whole response word
  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};

  // ****************************************************************
  // core reset sequencer
  // ****************************************************************
  ebrh_core_e  state_q;
  logic [7:0]  per_q;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= EBRH_RUN;
    else if (ce_i)
    begin
      unique case (state_q)
        EBRH_RUN:
          if (req_q)
            state_q <= EBRH_DRAIN;
        EBRH_DRAIN:
          if (core_pipe_empty_i)
            state_q <= EBRH_HELD;
        EBRH_HELD:
          if (!req_q)
            state_q <= EBRH_RUN;
      endcase
    end
  end

  // no system reset here: only the core is held
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      core_reset_o <= 1'b0;
    else if (ce_i)
      core_reset_o <= (state_q == EBRH_HELD) & req_q;
  end

  // one-cycle pulse on arrival, then again every period while held
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      per_q <= EBRH_CNT_RST;
    else if (ce_i)
    begin
      if (state_q != EBRH_HELD || per_q == EBRH_TAKEN_PER - 8'h01)
        per_q <= EBRH_CNT_RST;
      else
        per_q <= per_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      taken_q <= 1'b0;
    else if (ce_i)
      taken_q <= (state_q == EBRH_DRAIN && core_pipe_empty_i)
              || (state_q == EBRH_HELD && req_q && per_q == EBRH_TAKEN_PER - 8'h01);
  end

  assign reset_taken_o = taken_q;

  // release: restart strobe and fixed boot address
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      boot_fetch_o <= 1'b0;
    else if (ce_i)
      boot_fetch_o <= (state_q == EBRH_HELD) & ~req_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      boot_addr_o <= EBRH_RESET_ADDR;
    else if (ce_i)
      boot_addr_o <= EBRH_RESET_ADDR;
  end

endmodule

// file: rtl/ebrh_pkg.sv
package ebrh_pkg;

  // ****************************************************************
  // register map: printed indices, byte address is four times index
  // ****************************************************************
  localparam logic [1:0] EBRH_IDX_DATA = 2'h0;
  localparam logic [1:0] EBRH_IDX_MASK = 2'h2;
  localparam logic [1:0] EBRH_IDX_EDGE = 2'h3;
  localparam int         EBRH_AW       = 4;
  localparam logic [EBRH_AW-1:0] EBRH_ADR_DATA = {EBRH_IDX_DATA, 2'b00};
  localparam logic [EBRH_AW-1:0] EBRH_ADR_MASK = {EBRH_IDX_MASK, 2'b00};
  localparam logic [EBRH_AW-1:0] EBRH_ADR_EDGE = {EBRH_IDX_EDGE, 2'b00};

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         EBRH_BIT_PORT   = 0;
  localparam logic       EBRH_RST_REQ    = 1'b0;
  localparam logic       EBRH_RST_EDGE   = 1'b0;
  localparam logic       EBRH_RST_MASK   = 1'b0;
  localparam logic [31:0] EBRH_RST_RDATA = 32'h0000_0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          EBRH_CLK_MHZ       = 100;
  localparam int          EBRH_TAKEN_PER_NS  = 160;
  localparam int          EBRH_TAKEN_PER_CYC = (EBRH_TAKEN_PER_NS * EBRH_CLK_MHZ) / 1000;
  localparam logic [7:0]  EBRH_TAKEN_PER     = 8'(EBRH_TAKEN_PER_CYC);
  localparam logic [7:0]  EBRH_CNT_RST       = 8'h00;

  // core boot address, first word of program memory
  localparam logic [31:0] EBRH_RESET_ADDR = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    EBRH_RUN,
    EBRH_DRAIN,
    EBRH_HELD
  } ebrh_core_e;

  typedef struct packed {
    logic               cyc;
    logic               stb;
    logic               we;
    logic [3:0]         sel;
    logic [EBRH_AW-1:0] adr;
    logic [31:0]        dat;
  } ebrh_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ebrh_wb_rsp_s;

endpackage

// file: bench/ebrh_chk.sv
`timescale 1ns/100ps
module ebrh_chk
(
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   ce_i,
  // bus and core side
  input wire ebrh_pkg::ebrh_wb_req_s wb_req_i,
  input wire ebrh_pkg::ebrh_wb_rsp_s wb_rsp_o,
  input wire logic                   core_reset_o,
  input wire logic                   reset_taken_o,
  input wire logic                   boot_fetch_o,
  input wire logic [31:0]            boot_addr_o
);
  import ebrh_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && ce_i;
  endsequence
  sequence s_rd;
    s_req ##0 !wb_req_i.we;
  endsequence
  a_bus_answer: assert property (s_req |=> wb_rsp_o.ack) else $error("no ack");
  a_read_upper_zero: assert property (s_rd |=> wb_rsp_o.dat[31:1] == 31'h0) else $error("wide read");
  a_taken_pulse: assert property (reset_taken_o |=> !reset_taken_o) else $error("long pulse");
  a_taken_spacing: assert property (reset_taken_o |=> !reset_taken_o [*8]) else $error("pulses close");
  a_taken_holds: assert property (reset_taken_o |=> core_reset_o || boot_fetch_o) else $error("no hold");
  a_drain_first: assert property ($rose(core_reset_o) |-> $past(reset_taken_o)) else $error("early");
  a_boot_addr: assert property (boot_fetch_o |-> boot_addr_o == EBRH_RESET_ADDR) else $error("addr");
  a_boot_pulse: assert property (boot_fetch_o |=> !boot_fetch_o) else $error("fetch long");
endmodule
bind ebrh_top ebrh_chk u_ebrh_chk
(
  .clk_i         (clk_i),
  .rst_b_i       (rst_b_i),
  .ce_i          (ce_i),
  .wb_req_i      (wb_req_i),
  .wb_rsp_o      (wb_rsp_o),
  .core_reset_o  (core_reset_o),
  .reset_taken_o (reset_taken_o),
  .boot_fetch_o  (boot_fetch_o),
  .boot_addr_o   (boot_addr_o)
);

// file: bench/ebrh_core_model.sv
`timescale 1ns/100ps
module ebrh_core_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] lag_i,
  input  wire logic       core_reset_i,
  output      logic       pipe_empty_o
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= 8'h00;
    else if (cnt_q >= lag_i)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
  // running core is empty only briefly; a held core has nothing in flight
  assign pipe_empty_o = core_reset_i || (cnt_q == lag_i);
endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
  import ebrh_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic [7:0]   lag = 8'h03;
  logic         ce = 1'b1;
  // application entry, kept within reach of the boot branch
  localparam logic [31:0] ENTRY = 32'h0000_0400;
  // program words 0x0-0x1c, below the exception table
  logic [31:0]  ram [0:7];
  int           fetches = 0;
  ebrh_wb_req_s req = '0;
  ebrh_wb_rsp_s rsp;
  logic         empty, core_reset, taken, fetch, irq;
  logic [31:0]  baddr, rd;
  int           errors = 0;
  int           checks_done = 0;
  always #5 clk_i = ~clk_i;
  // the restart strobe lasts one cycle, so it is counted as it passes
  always @(posedge clk_i)
    if (fetch === 1'b1)
      fetches <= fetches + 1;
  ebrh_top u_ebrh_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .wb_req_i(req), .wb_rsp_o(rsp),
    .core_pipe_empty_i(empty), .core_reset_o(core_reset), .reset_taken_o(taken), .boot_fetch_o(fetch),
    .boot_addr_o(baddr), .irq_o(irq));
  ebrh_core_model u_ebrh_core_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .lag_i(lag),
    .core_reset_i(core_reset), .pipe_empty_o(empty));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each ack keeps the strobe from being driven twice
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do @(posedge clk_i); while (rsp.ack !== 1'b1 && ++n < 50);
    chk({31'h0, rsp.ack}, 32'h1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic t_map;
    wb(1'b1, 4'h4, 32'h1);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, EBRH_ADR_EDGE, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, core_reset}, 32'h0);
  endtask
  // request held up while the block is frozen must not be answered
  task automatic t_freeze;
    int n;
    n = 0;
    ce <= 1'b0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, sel: 4'hf, adr: EBRH_ADR_MASK, dat: 32'h1};
    repeat (4) @(posedge clk_i);
    chk({31'h0, rsp.ack}, 32'h0);
    ce <= 1'b1;
    do @(posedge clk_i); while (rsp.ack !== 1'b1 && ++n < 50);
    chk({31'h0, rsp.ack}, 32'h1);
    req <= '0;
    @(posedge clk_i);
    wb(1'b0, EBRH_ADR_MASK, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, EBRH_ADR_MASK, 32'h0);
  endtask
  task automatic t_boot(input logic [7:0] l);
    int n;
    lag <= l;
    wb(1'b1, EBRH_ADR_EDGE, 32'hdead_beef);
    wb(1'b0, EBRH_ADR_EDGE, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, EBRH_ADR_MASK, 32'h1);
    wb(1'b1, EBRH_ADR_DATA, 32'h1);
    n = 0;
    do wb(1'b0, EBRH_ADR_EDGE, 32'h0); while (rd[0] !== 1'b1 && ++n < 100);
    chk(rd, 32'h1);
    chk({31'h0, core_reset}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, EBRH_ADR_MASK, 32'h0);
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, EBRH_ADR_EDGE, 32'h0);
    repeat (20) @(posedge clk_i);
    wb(1'b0, EBRH_ADR_EDGE, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, EBRH_ADR_MASK, 32'h1);
    ram[EBRH_RESET_ADDR[4:2]] = ENTRY - EBRH_RESET_ADDR;
    n = fetches;
    wb(1'b1, EBRH_ADR_DATA, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(fetches - n, 32'h1);
    chk(baddr, EBRH_RESET_ADDR);
    chk(ram[baddr[4:2]], ENTRY - baddr);
    chk({31'h0, baddr < 32'h20 && baddr[1:0] == 2'h0}, 32'h1);
    chk({31'h0, ENTRY - baddr < 32'h1_0000}, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, core_reset}, 32'h0);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100us;
    errors++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_map();
    t_freeze();
    t_boot(8'h03);
    t_boot(8'h28);
    complete_run();
  end
endmodule
